// File: core/pord_map.svh
// Offsets, reset values and timing constants of the power-on block
// Function
// (R1) Hold reset output until power-up sequence completes
// (R2) Hold-pin mode: on request starts sequence, releases reset
// (R3) Hold-pin mode: shut down after window unless held
// (R4) Host raises hold pin within window, keeps it
// (R5) Hold pin falling edge is an off request
// (R6) Auto mode: keep-alive bit set at sequence end
// (R7) No auto-set: keep-alive bit replaces hold pin; the code selects it by ackMode, whatever autoSet is
// (R8) Host writes keep-alive bit to one, keeps it
// (R9) Boot pin selects stored region and sequence selector
// (R10) Boot pin latched at power-up end, readable
// (R11) Sequence branches on boot level, table unchanged
// (R12) Sequence is ordered series of register writes
// (R13) Software may overwrite settings after sequence completes
// (R14) Power-on reset clears every register domain
// (R15) Power-on domain survives hardware and switch-off resets
// (R16) Off request with hardware reset runs off sequence
// (R17) Off request without it does switch-off reset
// (R18) Hardware reset clears hardware and switch-off domains
// (R19) Switch-off reset clears only switch-off domain
// (R20) Reset levels nested: zero, one, two
// (R21) Power-on domain holds heat, short, mask, cause
// (R22) Hardware domain holds configuration and boot status
// (R23) Switch-off domain holds keep-alive and enables
// (R24) Window counter runs from clock, starts at active
`ifndef PORD_MAP_SVH
`define PORD_MAP_SVH
// ------------------------------------------------------------
// Register word offsets (byte address is offset times four)
// ------------------------------------------------------------
`define PORD_OFS_DEVCTL 6'h00
`define PORD_OFS_CFG 6'h01
`define PORD_OFS_STATUS 6'h02
`define PORD_OFS_CAUSE 6'h03
`define PORD_OFS_PORFLG 6'h04
`define PORD_OFS_RESEN 6'h05
// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define PORD_RST_ACKMODE 1'h0
`define PORD_RST_AUTOSET 1'h1
`define PORD_RST_OFFHW 1'h1
`define PORD_RST_MASK 8'hFF
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define PORD_CLK_KHZ 125000
`define PORD_HOLD_MS 8000
`define PORD_STEP_US 200
`define PORD_NRES 8
`endif

// File: core/pord_pkg.sv
// Types of the power-on block
package pord_pkg;
  typedef enum logic [2:0] {
    ST_OFF, ST_ONSEQ, ST_ACTIVE, ST_SLEEP, ST_OFFSEQ
  } pord_state_e;
  typedef enum logic [1:0] {SQ_ON, SQ_ACT_OFF, SQ_SLP_OFF} pord_seq_e;
  typedef struct packed {
    logic last;
    logic [7:0] en;
  } pord_op_s;
  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } pord_avm_s;
  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } pord_rsp_s;
endpackage

// File: core/pord_top.sv
// Power-on acknowledge, boot select and nested reset domains
//
// The address map and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ps
`include "pord_map.svh"
module pord_top #(
  parameter int unsigned HOLD_CYC = `PORD_HOLD_MS * `PORD_CLK_KHZ,
  parameter int unsigned STEP_CYC = `PORD_STEP_US * `PORD_CLK_KHZ / 1000
) (
  // Clock and power-on reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Avalon-MM slave
  input wire pord_pkg::pord_avm_s avm,
  output pord_pkg::pord_rsp_s avmRsp,
  // Pins
  input wire logic holdActivePin,
  input wire logic onReqPin,
  input wire logic bootPin,
  input wire logic sleepPin,
  input wire logic [3:0] heatIn,
  input wire logic [3:0] shortIn,
  // Outputs
  output logic rstOutN,
  output logic [`PORD_NRES-1:0] resEn
);
  import pord_pkg::*;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [11:0] syncA;
  logic [11:0] syncB;
  logic holdS;
  logic onS;
  logic bootS;
  logic sleepS;
  logic [3:0] heatS;
  logic [3:0] shortS;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      syncA <= 12'h000;
      syncB <= 12'h000;
    end else begin
      syncA <= {shortIn, heatIn, sleepPin, bootPin, onReqPin,
                holdActivePin};
      syncB <= syncA;
    end
  end

  assign holdS = syncB[0];
  assign onS = syncB[1];
  assign bootS = syncB[2];
  assign sleepS = syncB[3];
  assign heatS = syncB[7:4];
  assign shortS = syncB[11:8];

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  pord_state_e state;
  pord_seq_e seqKind;
  pord_op_s op;
  logic [2:0] stepIdx;
  logic [31:0] stepCnt;
  logic [31:0] holdCnt;
  logic windowOn;
  logic onPrev;
  logic keepPrev;
  logic keepSig;
  logic keepFall;
  logic windowExpire;
  logic running;
  logic offReq;
  logic stepTick;
  logic seqDone;
  logic onDone;
  logic hardwareLevelReset;
  logic switchoffLevelReset;
  logic ackMode;
  logic autoSet;
  logic offHw;
  logic [7:0] hwScratch;
  logic bootStatus;
  logic [2:0] cause;
  logic [3:0] heatFlg;
  logic [3:0] shortFlg;
  logic [7:0] pgoodMask;
  logic keepalive;
  logic [7:0] swoScratch;
  logic wrEn;
  logic [5:0] word;
  logic [31:0] rdMux;

  // ------------------------------------------------------------
  // Sequence table
  // ------------------------------------------------------------
  // Selector 1 branches inside the table rather than using a copy
  function automatic pord_op_s seqOp(input pord_seq_e k,
                                     input logic sel,
                                     input logic [2:0] i);
    pord_op_s r;
    r = '{last: 1'b1, en: 8'h00};
    unique case (k)
      SQ_ON: begin
        unique case (i)
          3'h0: r = '{last: 1'b0, en: 8'h01};
          3'h1: r = '{last: 1'b0, en: 8'h03};
          3'h2: r = '{last: 1'b0, en: sel ? 8'h0B : 8'h07};
          default: r = '{last: 1'b1, en: sel ? 8'h1B : 8'h0F};
        endcase
      end
      SQ_ACT_OFF: begin
        unique case (i)
          3'h0: r = '{last: 1'b0, en: 8'h07};
          3'h1: r = '{last: 1'b0, en: 8'h03};
          3'h2: r = '{last: 1'b0, en: 8'h01};
          default: r = '{last: 1'b1, en: 8'h00};
        endcase
      end
      default: begin
        if (i == 3'h0) begin
          r = '{last: 1'b0, en: 8'h01};
        end
      end
    endcase
    return r;
  endfunction

  assign op = seqOp(seqKind, bootS, stepIdx); // see (R9) see (R11)
  assign running = (state == ST_ONSEQ) || (state == ST_OFFSEQ);
  assign stepTick = running && (stepCnt == STEP_CYC - 1);
  assign seqDone = stepTick && op.last;
  assign onDone = seqDone && (state == ST_ONSEQ);

  // ------------------------------------------------------------
  // Acknowledge and off requests
  // ------------------------------------------------------------
  assign keepSig = ackMode ? keepalive : holdS; // see (R7)
  assign keepFall = keepPrev && !keepSig; // see (R5)
  assign windowExpire = windowOn && (holdCnt == HOLD_CYC - 1) &&
                        !keepSig; // see (R3)
  assign offReq = ((state == ST_ACTIVE) || (state == ST_SLEEP)) &&
                  (keepFall || windowExpire);
  // Reset level chosen by config at the end of the off sequence
  assign hardwareLevelReset = seqDone && (state == ST_OFFSEQ) &&
                              offHw; // see (R16)
  assign switchoffLevelReset = seqDone && (state == ST_OFFSEQ) &&
                               !offHw; // see (R17)

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      onPrev <= 1'b0;
      keepPrev <= 1'b0;
    end else begin
      onPrev <= onS;
      keepPrev <= keepSig;
    end
  end

  // Window counter; a 32-bit count covers the full 8 s default
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      windowOn <= 1'b0;
      holdCnt <= 32'h00000000;
    end else if (onDone) begin
      windowOn <= 1'b1; // see (R24)
      holdCnt <= 32'h00000000;
    end else if (windowOn) begin
      if (holdCnt == HOLD_CYC - 1 || state == ST_OFFSEQ) begin
        windowOn <= 1'b0;
      end
      holdCnt <= holdCnt + 32'h00000001;
    end
  end

  // ------------------------------------------------------------
  // State machine and reset output
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state <= ST_OFF;
      seqKind <= SQ_ON;
      rstOutN <= 1'b0;
    end else begin
      unique case (state)
        ST_OFF: begin
          if (onS && !onPrev) begin
            state <= ST_ONSEQ; // see (R2)
            seqKind <= SQ_ON;
          end
        end
        ST_ONSEQ: begin
          if (seqDone) begin
            state <= ST_ACTIVE;
            rstOutN <= 1'b1; // see (R1) see (R2)
          end
        end
        ST_ACTIVE: begin
          if (offReq) begin
            state <= ST_OFFSEQ;
            seqKind <= SQ_ACT_OFF; // see (R16) see (R17)
            rstOutN <= 1'b0;
          end else if (sleepS) begin
            state <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (offReq) begin
            state <= ST_OFFSEQ;
            seqKind <= SQ_SLP_OFF; // see (R16) see (R17)
            rstOutN <= 1'b0;
          end else if (!sleepS) begin
            state <= ST_ACTIVE;
          end
        end
        ST_OFFSEQ: begin
          if (seqDone) begin
            state <= ST_OFF;
          end
        end
      endcase
    end
  end

  // Step engine: each tick is one register write of the table
  always_ff @(posedge clk_sys) begin
    if (!rstn || !running) begin
      stepCnt <= 32'h00000000;
      stepIdx <= 3'h0;
    end else if (stepTick) begin
      stepCnt <= 32'h00000000;
      stepIdx <= stepIdx + 3'h1; // see (R12)
    end else begin
      stepCnt <= stepCnt + 32'h00000001;
    end
  end

  // ------------------------------------------------------------
  // Power-on domain, cleared by rstn only
  // ------------------------------------------------------------
  // Set wins over a write-one-to-clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      cause <= 3'h0; // see (R14) see (R20)
      heatFlg <= 4'h0;
      shortFlg <= 4'h0;
      pgoodMask <= `PORD_RST_MASK;
    end else begin // see (R15) see (R21)
      if (wrEn && word == `PORD_OFS_CAUSE) begin
        cause <= (cause & ~avm.writedata[2:0]) |
                 {hardwareLevelReset, windowExpire && offReq,
                  keepFall && offReq};
      end else begin
        cause <= cause |
                 {hardwareLevelReset, windowExpire && offReq,
                  keepFall && offReq};
      end
      if (wrEn && word == `PORD_OFS_PORFLG) begin
        heatFlg <= (heatFlg & ~avm.writedata[3:0]) | heatS;
        shortFlg <= (shortFlg & ~avm.writedata[7:4]) | shortS;
        pgoodMask <= avm.writedata[15:8];
      end else begin
        heatFlg <= heatFlg | heatS;
        shortFlg <= shortFlg | shortS;
      end
    end
  end

  // ------------------------------------------------------------
  // Hardware domain
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rstn || hardwareLevelReset) begin // see (R18) see (R20)
      ackMode <= `PORD_RST_ACKMODE;
      autoSet <= `PORD_RST_AUTOSET;
      offHw <= `PORD_RST_OFFHW;
      hwScratch <= 8'h00;
      bootStatus <= 1'b0;
    end else begin // see (R22)
      if (wrEn && word == `PORD_OFS_CFG) begin
        ackMode <= avm.writedata[0];
        autoSet <= avm.writedata[1];
        offHw <= avm.writedata[2];
        hwScratch <= avm.writedata[15:8];
      end
      if (onDone) begin
        bootStatus <= bootS; // see (R10)
      end
    end
  end

  // ------------------------------------------------------------
  // Switch-off domain
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rstn || hardwareLevelReset ||
        switchoffLevelReset) begin // see (R19) see (R20)
      keepalive <= 1'b0;
      resEn <= 8'h00;
      swoScratch <= 8'h00;
    end else begin // see (R23)
      if (onDone && ackMode && autoSet) begin
        keepalive <= 1'b1; // see (R6)
      end else if (wrEn && word == `PORD_OFS_DEVCTL) begin
        keepalive <= avm.writedata[0];
      end
      if (stepTick) begin
        resEn <= op.en; // see (R12)
      end else if (wrEn && word == `PORD_OFS_RESEN) begin
        resEn <= avm.writedata[7:0]; // see (R13)
        swoScratch <= avm.writedata[15:8];
      end
    end
  end

  // ------------------------------------------------------------
  // Avalon-MM slave
  // ------------------------------------------------------------
  // One wait cycle per access keeps readdata a plain flop
  assign word = avm.address[7:2];
  assign wrEn = avm.write && !avmRsp.waitrequest;

  always_comb begin
    unique case (word)
      `PORD_OFS_DEVCTL: rdMux = {31'h00000000, keepalive};
      `PORD_OFS_CFG: rdMux = {16'h0000, hwScratch, 5'h00, offHw,
                               autoSet, ackMode};
      `PORD_OFS_STATUS: rdMux = {26'h0000000, running, rstOutN,
                                  bootStatus, state};
      `PORD_OFS_CAUSE: rdMux = {29'h00000000, cause};
      `PORD_OFS_PORFLG: rdMux = {16'h0000, pgoodMask, shortFlg,
                                  heatFlg};
      `PORD_OFS_RESEN: rdMux = {16'h0000, swoScratch, resEn};
      default: rdMux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      avmRsp <= '{readdata: 32'h00000000, waitrequest: 1'b1};
    end else if ((avm.read || avm.write) && avmRsp.waitrequest) begin
      avmRsp.waitrequest <= 1'b0;
      avmRsp.readdata <= avm.read ? rdMux : 32'h00000000;
    end else begin
      avmRsp.waitrequest <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_reset_held_seq: assert property ( // see (R1)
    (state == ST_ONSEQ) |-> !rstOutN
  ) else $error("reset output released during power-up");
  a_reset_release: assert property ( // see (R2)
    onDone |=> rstOutN && state == ST_ACTIVE
  ) else $error("reset not released at sequence end");
  a_window_off: assert property ( // see (R3)
    (state == ST_ACTIVE && windowExpire) |=> state == ST_OFFSEQ
  ) else $error("no shutdown at window expiry");
  a_hold_fall_off: assert property ( // see (R5)
    ((state == ST_ACTIVE || state == ST_SLEEP) && !ackMode && holdS
      ##1 !holdS) |=> state == ST_OFFSEQ && !rstOutN
  ) else $error("hold pin fall not taken as off");
  a_auto_keep_set: assert property ( // see (R6)
    (onDone && ackMode && autoSet) |=> keepalive ##1 state != ST_OFFSEQ
  ) else $error("keep-alive bit not set");
  a_boot_latch: assert property ( // see (R10)
    onDone |=> bootStatus == $past(bootS)
  ) else $error("boot level not latched");
  a_hw_clears: assert property ( // see (R18)
    hardwareLevelReset |=> ackMode == `PORD_RST_ACKMODE &&
      resEn == 8'h00 && cause[2]
  ) else $error("hardware reset domains wrong");
  a_swo_keeps_hw: assert property ( // see (R19)
    switchoffLevelReset |=> $stable(ackMode) && $stable(hwScratch) &&
      !keepalive && $stable(cause)
  ) else $error("switch-off reset touched other domains");
  a_bus_answer: assert property (
    ((avm.read || avm.write) && avmRsp.waitrequest) |=>
      !avmRsp.waitrequest ##1 avmRsp.waitrequest
  ) else $error("bus answer not one cycle");
endmodule

// File: bench/pord_host.sv
// Host model that answers the device by driving the hold pin
`timescale 1ns/1ps
module pord_host (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Device side
  input wire logic rstOutN,
  output logic holdActivePin,
  // Bench command
  input wire logic keepOn,
  input wire logic [7:0] lateCyc
);
  // ------------------------------------------------------------
  // Hold pin
  // ------------------------------------------------------------
  logic [7:0] lagCnt;
  always_ff @(posedge clk_sys) begin
    if (!rstn || !keepOn) begin
      lagCnt <= 8'h00;
      holdActivePin <= 1'b0;
    end else if (rstOutN && !holdActivePin) begin
      // A slow host still answers inside the window
      lagCnt <= lagCnt + 8'h01;
      if (lagCnt == lateCyc) begin
        holdActivePin <= 1'b1;
      end
    end
  end
endmodule

// File: bench/power_on_ack_reset_domains_tb.sv
// Self-checking bench of the power-on block
`timescale 1ns/1ps
`include "pord_map.svh"
module power_on_ack_reset_domains_tb;
  import pord_pkg::*;
  // ------------------------------------------------------------
  // Setup
  // ------------------------------------------------------------
  // Short counts keep the run small
  localparam int unsigned HOLD = 200;
  localparam int unsigned STEP = 4;
  localparam logic [7:0] DEVCTL = {`PORD_OFS_DEVCTL, 2'b00};
  localparam logic [7:0] CFG = {`PORD_OFS_CFG, 2'b00};
  localparam logic [7:0] STAT = {`PORD_OFS_STATUS, 2'b00};
  localparam logic [7:0] CAUSE = {`PORD_OFS_CAUSE, 2'b00};
  localparam logic [7:0] FLG = {`PORD_OFS_PORFLG, 2'b00};
  localparam logic [7:0] RESEN = {`PORD_OFS_RESEN, 2'b00};
  logic clk_sys, rstn, holdActivePin, onReqPin, bootPin, sleepPin;
  logic keepOn, rstOutN;
  logic [3:0] heatIn, shortIn;
  logic [7:0] lateCyc, resEn;
  pord_avm_s avm;
  pord_rsp_s avmRsp;
  logic [31:0] q, r, scr;
  integer seed = 32'hCCC7;
  int errCount = 0;
  int checked = 0;

  pord_top #(.HOLD_CYC(HOLD), .STEP_CYC(STEP)) DUT (
    .clk_sys(clk_sys), .rstn(rstn), .avm(avm), .avmRsp(avmRsp),
    .holdActivePin(holdActivePin), .onReqPin(onReqPin),
    .bootPin(bootPin), .sleepPin(sleepPin), .heatIn(heatIn),
    .shortIn(shortIn), .rstOutN(rstOutN), .resEn(resEn));
  pord_host host (.clk_sys(clk_sys), .rstn(rstn), .rstOutN(rstOutN),
    .holdActivePin(holdActivePin), .keepOn(keepOn), .lateCyc(lateCyc));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function logic [31:0] upEn(input logic b);
    return b ? 32'h01030B1B : 32'h0103070F;
  endfunction
  function logic [31:0] stat(input logic [2:0] s, input logic b,
                             input logic o);
    return {27'h0, o, b, s};
  endfunction

  task stop_test;
    $display("Comparisons %0d, mismatches %0d", checked, errCount);
    if (errCount == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errCount++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Held until waitrequest is seen low; one idle edge follows
  // Only the watchdog ends a wait that never gets its answer
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    avm.address <= a;
    avm.write <= wr;
    avm.read <= !wr;
    avm.writedata <= d;
    do begin
      @(posedge clk_sys);
    end while (avmRsp.waitrequest !== 1'b0);
    q = avmRsp.readdata;
    avm.read <= 1'b0;
    avm.write <= 1'b0;
    if (wr) chk(q, 32'h0);
    @(posedge clk_sys);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask

  // Each step must change the enables; reset lets go with the last one
  task seq(input logic [31:0] e, input int n, input logic rel);
    logic [7:0] prev;
    int t;
    prev = resEn;
    for (int k = 0; k < n; k++) begin
      t = 0;
      do begin
        @(posedge clk_sys);
        t++;
      end while (resEn === prev && t < 400);
      prev = resEn;
      chk({24'h0, resEn}, {24'h0, e[31-8*k -: 8]});
      chk({31'h0, rstOutN}, {31'h0, rel && k == n - 1});
    end
  endtask

  task powerUp(input logic b, input logic [31:0] e);
    int t;
    bootPin <= b;
    onReqPin <= 1'b1;
    repeat (2) @(posedge clk_sys);
    onReqPin <= 1'b0;
    seq(e, 4, 1'b1);
    t = 0;
    while (rstOutN !== 1'b1 && t < 10) begin
      @(posedge clk_sys);
      t++;
    end
    chk({31'h0, rstOutN}, 32'h1);
  endtask

  initial begin
    repeat (5000) @(posedge clk_sys);
    errCount++;
    stop_test;
  end

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    avm = '0;
    onReqPin = 1'b0;
    bootPin = 1'b0;
    sleepPin = 1'b0;
    heatIn = 4'h0;
    shortIn = 4'h0;
    keepOn = 1'b0;
    lateCyc = 8'h00;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    rd(STAT, 32'h0);
    rd(CFG, 32'h6);
    rd(FLG, 32'hFF00);
    rd(8'h20, 32'h0);
    // Hold pin, boot low, off from sleep with hardware reset
    scr = $random(seed);
    bus(1'b1, CFG, {16'h0, scr[7:0], 8'h06});
    keepOn <= 1'b1;
    lateCyc <= 8'h64 + {2'b00, scr[13:8]};
    powerUp(1'b0, upEn(1'b0));
    rd(STAT, stat(3'h2, 1'b0, 1'b1));
    heatIn <= scr[19:16];
    shortIn <= scr[23:20];
    repeat (HOLD + 50) @(posedge clk_sys);
    heatIn <= 4'h0;
    shortIn <= 4'h0;
    chk({31'h0, rstOutN}, 32'h1);
    sleepPin <= 1'b1;
    repeat (8) @(posedge clk_sys);
    rd(STAT, stat(3'h3, 1'b0, 1'b1));
    keepOn <= 1'b0;
    seq(32'h01000000, 2, 1'b0);
    sleepPin <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rd(STAT, 32'h0);
    rd(CFG, 32'h6);
    rd(CAUSE, 32'h5);
    rd(FLG, {16'h0, 8'hFF, scr[23:16]});
    // Mask top bit kept low so it always differs from its reset value
    bus(1'b1, FLG, {16'h0, 1'b0, scr[14:8], 8'hFF});
    rd(FLG, {16'h0, 1'b0, scr[14:8], 8'h00});
    bus(1'b1, CAUSE, 32'h7);
    // Boot high, window expiry, switch-off reset only
    bus(1'b1, CFG, {16'h0, scr[31:24], 8'h02});
    powerUp(1'b1, upEn(1'b1));
    rd(STAT, stat(3'h2, 1'b1, 1'b1));
    r = $random(seed) | 32'h80;
    bus(1'b1, RESEN, r);
    rd(RESEN, r & 32'hFFFF);
    chk({24'h0, resEn}, {24'h0, r[7:0]});
    seq(32'h07030100, 4, 1'b0);
    repeat (4) @(posedge clk_sys);
    rd(CAUSE, 32'h2);
    rd(CFG, {16'h0, scr[31:24], 8'h02});
    rd(STAT, stat(3'h0, 1'b1, 1'b0));
    rd(RESEN, 32'h0);
    rd(FLG, {16'h0, 1'b0, scr[14:8], 8'h00});
    bus(1'b1, CAUSE, 32'h7);
    // Keep-alive bit with and without automatic setting
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, CFG, {29'h0, 1'b0, i == 0, 1'b1});
      powerUp(1'b0, upEn(1'b0));
      rd(DEVCTL, {31'h0, i == 0});
      if (i != 0) bus(1'b1, DEVCTL, 32'h1);
      repeat (HOLD + 50) @(posedge clk_sys);
      chk({31'h0, rstOutN}, 32'h1);
      bus(1'b1, DEVCTL, 32'h0);
      seq(32'h07030100, 4, 1'b0);
      repeat (4) @(posedge clk_sys);
      rd(CAUSE, 32'h1);
      bus(1'b1, CAUSE, 32'h7);
    end
    // Power-on reset in mid-run clears the hardware and power-on domains again
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    rd(CFG, 32'h6);
    rd(FLG, 32'hFF00);
    rd(STAT, 32'h0);
    stop_test;
  end
endmodule
